// File: ppp_mem_model.sv
/*
  Memory back end model: answers each request lat+1 cycles after it is seen.
  Assumes one request at a time, same clock as ppp_port.
*/
`timescale 1ns/100ps
`default_nettype none
module ppp_mem_model
  import ppp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request side
  input wire ppp_mem_req_t mem_req,
  input wire logic [7:0] lat,
  output logic mem_done,
  output logic [15:0] mem_rdata
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  logic [15:0] word_reg;
  // read data is only valid with done; it toggles otherwise
  always_ff @(posedge clk) begin
    mem_done <= 1'b0;
    if (reset) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
      mem_rdata <= 16'h0000;
    end else if (mem_req.valid) begin
      busy_reg <= 1'b1;
      cnt_reg <= lat;
      word_reg <= {mem_req.addr[7:0], mem_req.addr[15:8]} ^ 16'h3c00;
      mem_rdata <= ~mem_rdata;
    end else if (busy_reg && cnt_reg == 8'h00) begin
      busy_reg <= 1'b0;
      mem_done <= 1'b1;
      mem_rdata <= word_reg;
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : ppp_mem_model
`default_nettype wire

// File: ppp_pin_filter.sv
/*
  Three-stage input synchroniser with agreement filter for asynchronous pins.
  Assumes the inputs come from outside the clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module ppp_pin_filter #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // ----------------------------------------------------------------------
  // a bit changes once the second and third stages agree
  // ----------------------------------------------------------------------
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      out_reg <= RST;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign pin_out = out_reg;

endmodule : ppp_pin_filter
`default_nettype wire

// File: ppp_pkg.sv
/*
  Shared constants and types of the parallel programming port: action and
  byte-select codes, command bytes, timing counts and the signal groups.
  Assumes a single 125 MHz system clock.
*/
package ppp_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int ENTRY_STABLE_NS = 100;
  localparam int ENTRY_STABLE_CYCLES = (ENTRY_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] ENTRY_LAST_CNT = 4'(ENTRY_STABLE_CYCLES - 1);
  localparam logic [2:0] OSC_TOGGLES_MIN = 3'h6;
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;

  // ----------------------------------------------------------------------
  // pin encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  localparam logic [1:0] BS_LOW = 2'h0;
  localparam logic [1:0] BS_HIGH = 2'h1;
  localparam logic [1:0] BS_EXT = 2'h2;
  localparam logic [1:0] BS_RSVD = 2'h3;
  localparam logic [1:0] RDSEL_FUSE_LO = 2'h0;
  localparam logic [1:0] RDSEL_LOCK = 2'h1;
  localparam logic [1:0] RDSEL_FUSE_EXT = 2'h2;
  localparam logic [1:0] RDSEL_FUSE_HI = 2'h3;

  // ----------------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
  localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
  localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
  localparam logic [7:0] CMD_READ_SIG = 8'h08;
  localparam logic [7:0] CMD_READ_FUSE = 8'h04;
  localparam logic [7:0] CMD_READ_FLASH = 8'h02;
  localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    MOP_NONE = 4'h0,
    MOP_ERASE_FLASH = 4'h1,
    MOP_ERASE_EEPROM = 4'h2,
    MOP_ERASE_LOCK = 4'h3,
    MOP_PROG_FLASH_PAGE = 4'h4,
    MOP_PROG_EEPROM_PAGE = 4'h5,
    MOP_WRITE_FUSE = 4'h6,
    MOP_WRITE_LOCK = 4'h7,
    MOP_READ_FLASH = 4'h8,
    MOP_READ_EEPROM = 4'h9,
    MOP_READ_SIG = 4'ha
  } ppp_mop_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_ENTRY = 2'h1,
    MODE_PROG = 2'h2,
    MODE_FAIL = 2'h3
  } ppp_mode_t;

  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_WRITE = 3'h1,
    OP_READ = 3'h2,
    OP_ERASE_FLASH = 3'h3,
    OP_ERASE_EEPROM = 3'h4,
    OP_ERASE_LOCK = 3'h5
  } ppp_op_t;

  typedef struct packed {
    logic prog_voltage;
    logic load_strobe_clock;
    logic page_latch_strobe;
    logic action_select_1;
    logic action_select_0;
    logic byte_select_hi;
    logic byte_select_lo;
    logic wr_n;
    logic oe_n;
    logic [7:0] data;
  } ppp_pins_t;

  localparam ppp_pins_t PINS_RESET = '{prog_voltage: 1'b0, load_strobe_clock: 1'b0,
    page_latch_strobe: 1'b0, action_select_1: 1'b0, action_select_0: 1'b0, byte_select_hi: 1'b0,
    byte_select_lo: 1'b0, wr_n: 1'b1, oe_n: 1'b1, data: 8'h00};

  typedef struct packed {
    logic valid;
    ppp_mop_t op;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ppp_mem_req_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] ext;
    logic [7:0] lock;
  } ppp_fuse_t;

endpackage : ppp_pkg

// File: ppp_port.sv
/*
  Parallel programming port: pin sequencing, command/address/data loading,
  page buffer, erase and write sequencing, read-back onto the data bus.
  Assumes a memory back end that takes one request at a time and answers
  with mem_done, and pins that arrive asynchronously to clk.

*/
`timescale 1ns/100ps
`default_nettype none
module ppp_port
  import ppp_pkg::*;
#(
  parameter int PAGE_WORDS = 128
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // programming pins
  input wire ppp_pins_t pins_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_busy_out,
  output logic prog_mode,
  // memory back end
  output ppp_mem_req_t mem_req,
  input wire logic mem_done,
  input wire logic [15:0] mem_rdata,
  input wire ppp_fuse_t fuses,
  input wire logic eeprom_keep_fuse,
  // page buffer read port
  input wire logic [$clog2(PAGE_WORDS)-1:0] buf_rd_idx,
  output logic [15:0] buf_rd_word
);

  localparam int PB = $clog2(PAGE_WORDS);

  typedef struct packed {
    ppp_mode_t mode;
    ppp_op_t op;
    logic [3:0] entry_cnt;
    logic [2:0] toggles;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic [15:0] rd_word;
    ppp_pins_t last;
    ppp_mem_req_t mem;
    logic ready;
    logic [7:0] dout;
    logic doe;
    logic prog;
  } ppp_state_t;

  ppp_state_t st_reg;
  ppp_state_t st_next;
  ppp_pins_t p;
  logic buf_we;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [15:0] buf_rd_reg;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic ppp_mem_req_t mk_req(input ppp_mop_t op, input logic [23:0] a, input logic [15:0] d);
    ppp_mem_req_t r;
    r.valid = 1'b1;
    r.op = op;
    r.addr = a;
    r.wdata = d;
    return r;
  endfunction : mk_req

  // page base: word bits cleared, upper low-byte bits stay page bits
  function automatic logic [23:0] page_base(input logic [23:0] a);
    logic [23:0] m;
    m = ~((24'h000001 << PB) - 24'h000001);
    return a & m;
  endfunction : page_base

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  ppp_pin_filter #(
    .W($bits(ppp_pins_t)),
    .RST(PINS_RESET)
  ) u_filter (
    .clk(clk),
    .reset(reset),
    .pin_in(pins_in),
    .pin_out(p)
  );

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic ls_rise;
    logic pl_rise;
    logic wr_fall;
    logic oe_fall;
    logic pv_rise;
    logic [1:0] act;
    logic [1:0] bs;
    logic [3:0] entry_now;
    logic [3:0] entry_last;
    ls_rise = p.load_strobe_clock & ~st_reg.last.load_strobe_clock;
    pl_rise = p.page_latch_strobe & ~st_reg.last.page_latch_strobe;
    wr_fall = st_reg.last.wr_n & ~p.wr_n;
    oe_fall = st_reg.last.oe_n & ~p.oe_n;
    pv_rise = p.prog_voltage & ~st_reg.last.prog_voltage;
    act = {p.action_select_1, p.action_select_0};
    bs = {p.byte_select_hi, p.byte_select_lo};
    entry_now = {p.page_latch_strobe, p.action_select_1, p.action_select_0, p.byte_select_lo};
    entry_last = {st_reg.last.page_latch_strobe, st_reg.last.action_select_1,
                  st_reg.last.action_select_0, st_reg.last.byte_select_lo};
    st_next = st_reg;
    st_next.last = p;
    st_next.mem.valid = 1'b0;
    buf_we = 1'b0;

    unique case (st_reg.mode)
      MODE_OFF: begin
        st_next.ready = 1'b0;
        st_next.doe = 1'b0;
        if (!p.prog_voltage && ls_rise && st_reg.toggles != OSC_TOGGLES_MIN) begin
          st_next.toggles = st_reg.toggles + 3'h1;
        end
        if (pv_rise) begin
          if (st_reg.toggles == OSC_TOGGLES_MIN && entry_now == ENTRY_PATTERN) begin
            st_next.mode = MODE_ENTRY;
            st_next.entry_cnt = 4'h0;
          end else begin
            st_next.mode = MODE_FAIL;
          end
        end
      end
      MODE_ENTRY: begin
        if (!p.prog_voltage || entry_now != entry_last) begin
          st_next.mode = MODE_FAIL;
        end else if (st_reg.entry_cnt == ENTRY_LAST_CNT) begin
          st_next.mode = MODE_PROG;
          st_next.op = OP_IDLE;
          st_next.cmd = CMD_NOP;
          st_next.ready = 1'b1;
        end else begin
          st_next.entry_cnt = st_reg.entry_cnt + 4'h1;
        end
      end
      MODE_FAIL: st_next.mode = MODE_FAIL; // waits for the voltage to drop
      MODE_PROG: begin
        st_next.doe = ~p.oe_n;
        // loads, only while no operation runs
        if (ls_rise && st_reg.op == OP_IDLE) begin
          unique case (act)
            ACT_ADDR: begin
              unique case (bs)
                BS_LOW: st_next.addr[7:0] = p.data;
                BS_HIGH: st_next.addr[15:8] = p.data;
                BS_EXT: st_next.addr[23:16] = p.data;
                BS_RSVD: st_next.addr = st_reg.addr;
              endcase
            end
            ACT_DATA: begin
              if (!p.byte_select_hi && p.byte_select_lo) begin
                st_next.data_hi = p.data;
              end else if (!p.byte_select_hi) begin
                st_next.data_lo = p.data;
              end
            end
            ACT_CMD: st_next.cmd = p.data;
            ACT_IDLE: st_next.cmd = st_reg.cmd;
          endcase
        end
        // page latch into the buffer at the current word
        if (pl_rise && p.byte_select_lo && st_reg.op == OP_IDLE &&
            (st_reg.cmd == CMD_WRITE_FLASH || st_reg.cmd == CMD_WRITE_EEPROM)) begin
          buf_we = 1'b1;
        end
        // write strobe runs the loaded command
        if (wr_fall && st_reg.op == OP_IDLE) begin
          unique case (st_reg.cmd)
            CMD_CHIP_ERASE: begin
              st_next.mem = mk_req(MOP_ERASE_FLASH, 24'h000000, 16'h0000);
              st_next.op = OP_ERASE_FLASH;
            end
            CMD_WRITE_FLASH, CMD_WRITE_EEPROM: begin
              if (bs == BS_LOW) begin
                st_next.mem = mk_req(st_reg.cmd == CMD_WRITE_FLASH ? MOP_PROG_FLASH_PAGE :
                                     MOP_PROG_EEPROM_PAGE, page_base(st_reg.addr), 16'h0000);
                st_next.op = OP_WRITE;
              end
            end
            CMD_WRITE_FUSE: begin
              if (bs != BS_RSVD) begin
                st_next.mem = mk_req(MOP_WRITE_FUSE, {22'h000000, bs}, {8'h00, st_reg.data_lo});
                st_next.op = OP_WRITE;
              end
            end
            CMD_WRITE_LOCK: begin
              st_next.mem = mk_req(MOP_WRITE_LOCK, 24'h000000, {8'h00, st_reg.data_lo});
              st_next.op = OP_WRITE;
            end
            default: st_next.op = st_reg.op;
          endcase
          if (st_next.mem.valid) begin
            st_next.ready = 1'b0;
          end
        end
        // read strobe fetches the addressed word
        if (oe_fall && st_reg.op == OP_IDLE) begin
          unique case (st_reg.cmd)
            CMD_READ_FLASH, CMD_READ_EEPROM, CMD_READ_SIG: begin
              st_next.mem = mk_req(st_reg.cmd == CMD_READ_FLASH ? MOP_READ_FLASH : st_reg.cmd == CMD_READ_SIG ?
                                   MOP_READ_SIG : MOP_READ_EEPROM, st_reg.addr, 16'h0000);
              st_next.op = OP_READ;
            end
            default: st_next.op = st_reg.op;
          endcase
        end
        // completion of the running operation
        if (mem_done) begin
          unique case (st_reg.op)
            OP_WRITE: begin
              st_next.op = OP_IDLE;
              st_next.ready = 1'b1;
            end
            OP_READ: begin
              st_next.op = OP_IDLE;
              st_next.rd_word = mem_rdata;
            end
            OP_ERASE_FLASH: begin
              st_next.mem = mk_req(eeprom_keep_fuse ? MOP_ERASE_LOCK : MOP_ERASE_EEPROM,
                                   24'h000000, 16'h0000);
              st_next.op = eeprom_keep_fuse ? OP_ERASE_LOCK : OP_ERASE_EEPROM;
            end
            OP_ERASE_EEPROM: begin
              st_next.mem = mk_req(MOP_ERASE_LOCK, 24'h000000, 16'h0000);
              st_next.op = OP_ERASE_LOCK;
            end
            OP_ERASE_LOCK: begin
              st_next.op = OP_IDLE;
              st_next.ready = 1'b1;
            end
            default: st_next.op = OP_IDLE;
          endcase
        end
        // read data for the bus, selected by the byte selects; EEPROM reads always give the low byte
        unique case (st_reg.cmd)
          CMD_READ_FLASH: st_next.dout = p.byte_select_lo ? st_reg.rd_word[15:8] : st_reg.rd_word[7:0];
          CMD_READ_EEPROM: st_next.dout = st_reg.rd_word[7:0];
          CMD_READ_SIG: st_next.dout = p.byte_select_lo ? st_reg.rd_word[15:8] : st_reg.rd_word[7:0];
          CMD_READ_FUSE: begin
            unique case (bs)
              RDSEL_FUSE_LO: st_next.dout = fuses.low;
              RDSEL_LOCK: st_next.dout = fuses.lock;
              RDSEL_FUSE_EXT: st_next.dout = fuses.ext;
              RDSEL_FUSE_HI: st_next.dout = fuses.high;
            endcase
          end
          default: st_next.dout = 8'h00;
        endcase
      end
    endcase

    // leaving high voltage ends any mode
    if (!p.prog_voltage && st_reg.mode != MODE_OFF) begin
      st_next.mode = MODE_OFF;
      st_next.op = OP_IDLE;
      st_next.toggles = 3'h0;
      st_next.cmd = CMD_NOP;
      st_next.ready = 1'b0;
      st_next.doe = 1'b0;
    end
    st_next.prog = (st_next.mode == MODE_PROG);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.last <= PINS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // page buffer, word index from low address bits
  always_ff @(posedge clk) begin
    if (buf_we) begin
      buf_mem[st_reg.addr[PB-1:0]] <= {st_reg.data_hi, st_reg.data_lo};
    end
    if (reset) begin
      buf_rd_reg <= 16'h0000;
    end else begin
      buf_rd_reg <= buf_mem[buf_rd_idx];
    end
  end

  assign data_out = st_reg.dout;
  assign data_oe = st_reg.doe;
  assign ready_busy_out = st_reg.ready;
  assign prog_mode = st_reg.prog;
  assign mem_req = st_reg.mem;
  assign buf_rd_word = buf_rd_reg;

endmodule : ppp_port
`default_nettype wire

// File: ppp_port_chk.sv
/*
  Concurrent checks on the ports of ppp_port.
  Assumes one clock, synchronous active-high reset, bound to every ppp_port.
*/
`timescale 1ns/100ps
`default_nettype none
module ppp_port_chk
  import ppp_pkg::*;
#(
  parameter int PAGE_WORDS = 128
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire ppp_pins_t pins_in,
  input wire logic data_oe,
  input wire logic ready_busy_out,
  input wire logic prog_mode,
  input wire ppp_mem_req_t mem_req,
  input wire logic mem_done,
  input wire logic eeprom_keep_fuse
);
  localparam int PB = $clog2(PAGE_WORDS);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  oe_idle_a: assert property (pins_in.oe_n [*8] |=> !data_oe)
    else $error("data bus driven without read strobe");
  oe_mode_a: assert property (!prog_mode && !$past(prog_mode) |-> !data_oe)
    else $error("data bus driven outside program mode");
  rdy_mode_a: assert property (!prog_mode && !$past(prog_mode) |-> !ready_busy_out)
    else $error("ready shown outside program mode");
  busy_req_a: assert property (mem_req.valid && mem_req.op != MOP_READ_FLASH
    && mem_req.op != MOP_READ_EEPROM && mem_req.op != MOP_READ_SIG |-> !ready_busy_out)
    else $error("write started while ready high");
  done_rdy_a: assert property (prog_mode && mem_done && mem_req.op inside {MOP_PROG_FLASH_PAGE,
    MOP_PROG_EEPROM_PAGE, MOP_ERASE_LOCK, MOP_WRITE_FUSE, MOP_WRITE_LOCK} |=> ready_busy_out)
    else $error("ready not back after last completion");
  erase_seq_a: assert property (prog_mode && mem_done && mem_req.op == MOP_ERASE_FLASH
    |=> mem_req.valid && mem_req.op == (eeprom_keep_fuse ? MOP_ERASE_LOCK : MOP_ERASE_EEPROM))
    else $error("erase step out of order");
  keep_eep_a: assert property (mem_req.valid && eeprom_keep_fuse |-> mem_req.op != MOP_ERASE_EEPROM)
    else $error("eeprom erased while preserved");
  page_addr_a: assert property (mem_req.valid && mem_req.op inside {MOP_PROG_FLASH_PAGE, MOP_PROG_EEPROM_PAGE}
    |-> mem_req.addr[PB-1:0] == '0)
    else $error("page write address not page aligned");
  fuse_addr_a: assert property (mem_req.valid && mem_req.op == MOP_WRITE_FUSE |-> mem_req.addr < 24'h3)
    else $error("fuse write byte out of range");
  req_pulse_a: assert property (mem_req.valid |=> !mem_req.valid)
    else $error("request longer than one cycle");
  entry_time_a: assert property ($rose(prog_mode) |-> $past(pins_in.prog_voltage, 13))
    else $error("program mode entered too early");
  entry_rdy_a: assert property ($rose(prog_mode) |-> ##[0:2] ready_busy_out)
    else $error("not ready after entry");
  erase_c: cover property (mem_req.valid && mem_req.op == MOP_ERASE_LOCK);
  entry_c: cover property ($rose(prog_mode));
  read_c: cover property ($rose(data_oe));
endmodule : ppp_port_chk
bind ppp_port ppp_port_chk #(.PAGE_WORDS(PAGE_WORDS)) u_ppp_port_chk (.clk(clk), .reset(reset),
  .pins_in(pins_in), .data_oe(data_oe), .ready_busy_out(ready_busy_out), .prog_mode(prog_mode),
  .mem_req(mem_req), .mem_done(mem_done), .eeprom_keep_fuse(eeprom_keep_fuse));
`default_nettype wire

// File: ppp_port_tb.sv
/*
  Self-checking testbench for ppp_port; the tasks play the programmer.
  Assumes ppp_mem_model as back end and a 16-word page.
*/
`timescale 1ns/100ps
`default_nettype none
module ppp_port_tb;
  import ppp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  ppp_pins_t pins;
  logic [7:0] data_out;
  logic data_oe;
  logic ready_busy_out;
  logic prog_mode;
  ppp_mem_req_t mem_req;
  logic mem_done;
  logic [15:0] mem_rdata;
  ppp_fuse_t fuses = '{low: 8'hc1, high: 8'h99, ext: 8'hfd, lock: 8'h3f};
  logic eeprom_keep_fuse = 1'b0;
  logic [3:0] idx = 4'h0;
  logic [15:0] buf_word;
  logic [7:0] lat = 8'd20;
  int errors = 0;
  int compares = 0;
  ppp_mop_t ops[$];
  always #4 clk = ~clk;
  always @(posedge clk) if (mem_req.valid === 1'b1) ops.push_back(mem_req.op);
  ppp_port #(.PAGE_WORDS(16)) u_ppp_port (.clk(clk), .reset(reset), .pins_in(pins), .data_out(data_out),
    .data_oe(data_oe), .ready_busy_out(ready_busy_out), .prog_mode(prog_mode), .mem_req(mem_req),
    .mem_done(mem_done), .mem_rdata(mem_rdata), .fuses(fuses), .eeprom_keep_fuse(eeprom_keep_fuse),
    .buf_rd_idx(idx), .buf_rd_word(buf_word));
  ppp_mem_model u_ppp_mem_model (.clk(clk), .reset(reset), .mem_req(mem_req), .lat(lat),
    .mem_done(mem_done), .mem_rdata(mem_rdata));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready_busy_out !== 1'b1 && n < 3000) begin
      hold(1);
      n++;
    end
    if (n == 3000) begin
      errors++;
      $display("ERROR %0t: ready wait timed out", $time);
      print_verdict();
    end
  endtask : wait_rdy
  task automatic load(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    {pins.action_select_1, pins.action_select_0} = a;
    {pins.byte_select_hi, pins.byte_select_lo} = b;
    pins.data = d;
    hold(6);
    pins.load_strobe_clock = 1'b1;
    hold(6);
    pins.load_strobe_clock = 1'b0;
    hold(6);
  endtask : load
  task automatic pulse_wr(input logic [1:0] b);
    ops.delete();
    {pins.byte_select_hi, pins.byte_select_lo} = b;
    hold(6);
    pins.wr_n = 1'b0;
    hold(8);
    pins.wr_n = 1'b1;
    hold(6);
  endtask : pulse_wr
  task automatic rd(input logic [1:0] b, input logic [7:0] e);
    {pins.byte_select_hi, pins.byte_select_lo} = b;
    pins.oe_n = 1'b0;
    hold(40);
    chk(data_oe, 1'b1);
    chk(data_out, e);
    pins.oe_n = 1'b1;
    hold(8);
    chk(data_oe, 1'b0);
  endtask : rd
  task automatic enter();
    pins = PINS_RESET;
    hold(6);
    repeat (6) begin
      pins.load_strobe_clock = 1'b1;
      hold(6);
      pins.load_strobe_clock = 1'b0;
      hold(6);
    end
    hold(14);
    pins.prog_voltage = 1'b1;
  endtask : enter
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_entry_fail();
    enter();
    hold(2);
    pins.page_latch_strobe = 1'b1;
    hold(6);
    pins.page_latch_strobe = 1'b0;
    hold(40);
    chk(prog_mode, 1'b0);
    chk(ready_busy_out, 1'b0);
    pins.prog_voltage = 1'b0;
    hold(10);
  endtask : t_entry_fail
  task automatic t_entry();
    enter();
    hold(40);
    chk(prog_mode, 1'b1);
    chk(ready_busy_out, 1'b1);
    hold(6250);
  endtask : t_entry
  task automatic t_erase(input logic keep);
    eeprom_keep_fuse = keep;
    load(ACT_CMD, BS_LOW, CMD_CHIP_ERASE);
    pulse_wr(BS_LOW);
    chk(ready_busy_out, 1'b0);
    wait_rdy();
    chk(24'(ops.size()), keep ? 24'h2 : 24'h3);
    chk(ops[0], MOP_ERASE_FLASH);
    chk(ops[ops.size() - 1], MOP_ERASE_LOCK);
  endtask : t_erase
  task automatic t_page();
    load(ACT_CMD, BS_LOW, CMD_WRITE_FLASH);
    load(ACT_ADDR, BS_LOW, 8'h85);
    load(ACT_ADDR, BS_HIGH, 8'h12);
    load(ACT_ADDR, BS_EXT, 8'h03);
    load(ACT_ADDR, BS_RSVD, 8'hff);
    load(ACT_DATA, BS_LOW, 8'h34);
    load(ACT_DATA, BS_HIGH, 8'h56);
    load(ACT_IDLE, BS_HIGH, 8'h77);
    pins.page_latch_strobe = 1'b1;
    hold(6);
    pins.page_latch_strobe = 1'b0;
    idx = 4'h5;
    hold(6);
    chk(buf_word, 16'h5634);
    pulse_wr(BS_LOW);
    chk(ready_busy_out, 1'b0);
    wait_rdy();
    chk(24'(ops.size()), 24'h1);
    chk(mem_req.op, MOP_PROG_FLASH_PAGE);
    chk(mem_req.addr, 24'h031280);
    load(ACT_CMD, BS_LOW, CMD_WRITE_EEPROM);
    pulse_wr(BS_LOW);
    chk(ready_busy_out, 1'b0);
    wait_rdy();
    chk(mem_req.op, MOP_PROG_EEPROM_PAGE);
    load(ACT_CMD, BS_LOW, CMD_NOP);
    pulse_wr(BS_LOW);
    hold(10);
    chk(24'(ops.size()), 24'h0);
  endtask : t_page
  task automatic t_read();
    logic [15:0] w;
    w = {8'h85, 8'h12} ^ 16'h3c00;
    load(ACT_CMD, BS_LOW, CMD_READ_FLASH);
    rd(2'h0, w[7:0]);
    rd(2'h1, w[15:8]);
    load(ACT_CMD, BS_LOW, CMD_READ_EEPROM);
    rd(2'h0, w[7:0]);
    load(ACT_CMD, BS_LOW, CMD_READ_SIG);
    rd(2'h0, w[7:0]);
    load(ACT_CMD, BS_LOW, CMD_READ_FUSE);
    rd(RDSEL_FUSE_LO, fuses.low);
    rd(RDSEL_LOCK, fuses.lock);
    rd(RDSEL_FUSE_EXT, fuses.ext);
    rd(RDSEL_FUSE_HI, fuses.high);
  endtask : t_read
  task automatic t_fuse();
    lat = 8'd0;
    load(ACT_CMD, BS_LOW, CMD_WRITE_FUSE);
    load(ACT_DATA, BS_LOW, 8'h5a);
    for (int b = 0; b < 3; b++) begin
      pulse_wr(2'(b));
      wait_rdy();
      chk(mem_req.op, MOP_WRITE_FUSE);
      chk(mem_req.addr, 24'(b));
      chk(mem_req.wdata, 16'h005a);
    end
    load(ACT_CMD, BS_LOW, CMD_WRITE_LOCK);
    pulse_wr(BS_LOW);
    wait_rdy();
    chk(mem_req.op, MOP_WRITE_LOCK);
  endtask : t_fuse
  initial begin
    pins = PINS_RESET;
    hold(20);
    reset = 1'b0;
    hold(4);
    t_entry_fail();
    t_entry();
    t_erase(1'b0);
    t_erase(1'b1);
    t_page();
    t_read();
    t_fuse();
    print_verdict();
  end
endmodule : ppp_port_tb
`default_nettype wire
